/* inc/ofm_consts.svh */
// register offsets, field positions, reset values and timing counts of the frequency monitor
`ifndef OFM_CONSTS_SVH
`define OFM_CONSTS_SVH

// ==========================================================
// register byte offsets
`define OFM_ADDR_KEY      8'h00
`define OFM_ADDR_ENABLE   8'h04
`define OFM_ADDR_LOWER    8'h08
`define OFM_ADDR_UPPER    8'h0C
`define OFM_ADDR_RSTGEN   8'h10
`define OFM_ADDR_STATUS   8'h14
`define OFM_ADDR_IRQ_STAT 8'h18
`define OFM_ADDR_IRQ_MASK 8'h1C

// ==========================================================
// codes and reset values
`define OFM_KEY_LOCK      8'h06
`define OFM_KEY_OPEN      8'hF9
`define OFM_EN_OFF        8'h00
`define OFM_EN_ON         8'hE4
`define OFM_LIMIT_RST     9'h000
`define OFM_RSTGEN_RST    1'b1
`define OFM_IRQ_MASK_RST  2'h0

// ==========================================================
// field positions
`define OFM_ST_FAULT_BIT  0
`define OFM_ST_STOP_BIT   1
`define OFM_IRQ_FAULT_BIT 0
`define OFM_IRQ_REFST_BIT 1

// ==========================================================
// timing
`define OFM_ARM_EDGES     2'h2
`define OFM_CLK_PERIOD_NS 40
`define OFM_REF_STOP_NS   2560
`define OFM_REF_STOP_CYC  ((`OFM_REF_STOP_NS) / (`OFM_CLK_PERIOD_NS))

`endif

/* inc/ofm_pkg.sv */
// types shared by the frequency monitor files
package ofm_pkg;

    typedef enum logic [2:0] {
        OFM_IDLE = 3'b001,
        OFM_ARM  = 3'b010,
        OFM_MEAS = 3'b100
    } ofm_state_t;

    typedef logic [8:0] ofm_limit_t;

endpackage

/* inc/ofm_edge_if.sv */
// sampled clock edge carried from the edge sampler to the monitor core
`timescale 1ns/1ns
interface ofm_edge_if;
    logic rise;
    logic level;
    modport src (output rise, output level);
    modport dst (input rise, input level);
endinterface

/* verilog/ofm_edge_sync.sv */
// two-flop sampler and rising-edge detector for a clock taken as a plain input
`timescale 1ns/1ns
module ofm_edge_sync
(
    // system
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // sampled pin
    input  wire logic pin_in,
    // edge out
    ofm_edge_if.src   edge_o
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // ==========================================================
    // synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r; // R18
            last_r <= sync_r;
        end
    end

    assign edge_o.rise  = sync_r & ~last_r;
    assign edge_o.level = sync_r;

endmodule // ofm_edge_sync

/* verilog/ofm_freq_monitor.sv */
// oscillation frequency monitor: key-protected registers, window counter, limit compare
// Operation
// R1: status bit 1 shows monitor stopped
// R2: status bit 0 flags frequency fault
// R3: writes locked until key holds 0xF9
// R4: writing 0xE4 with key open starts detection
// R5: software relocks with 0x06 after setup
// R6: software reconfigures only while stopped
// R7: wait two target edges before evaluating
// R8: 256 reference edges window, target divided four
// R9: fault when count above upper, below lower
// R10: fault when reference clock stops
// R11: fault with reset enabled requests warm reset
// R12: run only in normal or idle mode
// R13: two 9-bit limit registers, low bits
// R14: reset-generate enable bit 0, resets to 1
// R15: other key values store 0x06
// R16: enable accepts only 0x00 or 0xE4
// R17: limits and reset-enable locked while running
// R18: target count synchronised before compare
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
`include "ofm_consts.svh"
module ofm_freq_monitor
(
    // system
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // monitored clocks, sampled as inputs
    input  wire logic        target_clk_in,
    input  wire logic        ref_clk_in,
    // power mode: high in normal or idle mode
    input  wire logic        pmode_ok,
    // outputs
    output logic             warm_rst_req,
    output logic             irq
);

    ofm_edge_if tgt_e ();
    ofm_edge_if ref_e ();

    ofm_edge_sync u_tgt_sync
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (target_clk_in),
        .edge_o  (tgt_e)
    );

    ofm_edge_sync u_ref_sync
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (ref_clk_in),
        .edge_o  (ref_e)
    );

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = reg_wr && (reg_addr == a);
    endfunction

    // ==========================================================
    // registers
    logic [7:0]          key_r;
    logic [7:0]          en_r;
    ofm_pkg::ofm_limit_t lower_r;
    ofm_pkg::ofm_limit_t upper_r;
    logic                rstgen_r;
    logic                fault_r;
    logic [1:0]          irq_stat_r;
    logic [1:0]          irq_mask_r;
    logic                soft_init;
    logic                running;
    logic                key_open;
    logic [7:0]          wkey;

    assign running  = (en_r == `OFM_EN_ON);
    assign key_open = (key_r == `OFM_KEY_OPEN);
    assign wkey     = reg_wdata[7:0];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            key_r <= `OFM_KEY_LOCK;
        else if (soft_init)
            key_r <= `OFM_KEY_LOCK;
        else if (wr_at(`OFM_ADDR_KEY))
            key_r <= (wkey == `OFM_KEY_OPEN) ? `OFM_KEY_OPEN : `OFM_KEY_LOCK; // R15
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            en_r <= `OFM_EN_OFF;
        else if (soft_init)
            en_r <= `OFM_EN_OFF;
        else if (wr_at(`OFM_ADDR_ENABLE) && key_open) // R3 R4
        begin
            if (wkey == `OFM_EN_OFF || wkey == `OFM_EN_ON) // R16
                en_r <= wkey;
        end
    end

    // configuration writes need the key and a stopped monitor
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lower_r  <= `OFM_LIMIT_RST;
            upper_r  <= `OFM_LIMIT_RST;
            rstgen_r <= `OFM_RSTGEN_RST; // R14
        end
        else if (soft_init)
        begin
            lower_r  <= `OFM_LIMIT_RST;
            upper_r  <= `OFM_LIMIT_RST;
            rstgen_r <= `OFM_RSTGEN_RST;
        end
        else if (key_open && !running) // R3 R17
        begin
            if (wr_at(`OFM_ADDR_LOWER))
                lower_r <= reg_wdata[8:0]; // R13
            if (wr_at(`OFM_ADDR_UPPER))
                upper_r <= reg_wdata[8:0]; // R13
            if (wr_at(`OFM_ADDR_RSTGEN))
                rstgen_r <= reg_wdata[0]; // R14
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask_r <= `OFM_IRQ_MASK_RST;
        else if (wr_at(`OFM_ADDR_IRQ_MASK))
            irq_mask_r <= reg_wdata[1:0];
    end

    // ==========================================================
    // measurement sequencer
    ofm_pkg::ofm_state_t state_r;
    logic [1:0]          arm_cnt_r;
    logic [7:0]          win_cnt_r;
    logic [11:0]         tgt_cnt_r;
    logic [9:0]          tgt_div4;
    logic                win_end;
    logic                freq_bad;
    logic                ref_stop;
    logic                fault_evt;
    logic [7:0]          stop_cnt_r;
    logic                active;

    // measuring halts outside normal and idle mode
    assign active    = running && pmode_ok; // R12
    assign win_end   = (state_r == ofm_pkg::OFM_MEAS) && ref_e.rise && (win_cnt_r == 8'hFF);
    assign tgt_div4  = tgt_cnt_r[11:2]; // R8 R18
    assign freq_bad  = win_end && ((tgt_div4 > {1'b0, upper_r}) ||
                                   (tgt_div4 < {1'b0, lower_r})); // R9
    assign ref_stop  = (state_r != ofm_pkg::OFM_IDLE) && active &&
                       (stop_cnt_r == 8'(`OFM_REF_STOP_CYC - 1)) && !ref_e.rise; // R10
    assign fault_evt = freq_bad || ref_stop;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= ofm_pkg::OFM_IDLE;
            arm_cnt_r <= 2'h0;
        end
        else if (soft_init || !running)
        begin
            state_r   <= ofm_pkg::OFM_IDLE;
            arm_cnt_r <= 2'h0;
        end
        else if (active)
        begin
            unique case (state_r)
                ofm_pkg::OFM_IDLE:
                    state_r <= ofm_pkg::OFM_ARM;
                ofm_pkg::OFM_ARM:
                    if (tgt_e.rise)
                    begin
                        arm_cnt_r <= arm_cnt_r + 2'h1;
                        if (arm_cnt_r == `OFM_ARM_EDGES - 2'h1)
                            state_r <= ofm_pkg::OFM_MEAS; // R7
                    end
                ofm_pkg::OFM_MEAS:
                    state_r <= ofm_pkg::OFM_MEAS;
            endcase
        end
    end

    // window of reference edges, target edges counted with saturation
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_cnt_r <= 8'h00;
            tgt_cnt_r <= 12'h000;
        end
        else if (state_r != ofm_pkg::OFM_MEAS || !active || win_end)
        begin
            win_cnt_r <= 8'h00;
            tgt_cnt_r <= 12'h000;
        end
        else
        begin
            if (ref_e.rise)
                win_cnt_r <= win_cnt_r + 8'h01; // R8
            if (tgt_e.rise && tgt_cnt_r != 12'hFFF)
                tgt_cnt_r <= tgt_cnt_r + 12'h001;
        end
    end

    // sys cycles since last reference edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stop_cnt_r <= 8'h00;
        else if (state_r == ofm_pkg::OFM_IDLE || !active || ref_e.rise || ref_stop)
            stop_cnt_r <= 8'h00;
        else
            stop_cnt_r <= stop_cnt_r + 8'h01; // R10
    end

    // ==========================================================
    // fault flag and reset request
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            fault_r <= 1'b0;
        else if (fault_evt)
            fault_r <= 1'b1; // R2
        else if (wr_at(`OFM_ADDR_ENABLE) && key_open && wkey == `OFM_EN_ON && !running)
            fault_r <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            warm_rst_req <= 1'b0;
        else
            warm_rst_req <= fault_evt && rstgen_r; // R11
    end

    // the requested warm reset also returns key, enable, limits, reset-enable and sequencer to reset state
    assign soft_init = warm_rst_req; // R11

    // ==========================================================
    // interrupt status, cleared by reading it; a new event wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_r <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == `OFM_IRQ_FAULT_BIT && freq_bad) ||
                    (i == `OFM_IRQ_REFST_BIT && ref_stop))
                    irq_stat_r[i] <= 1'b1;
                else if (reg_rd && reg_addr == `OFM_ADDR_IRQ_STAT)
                    irq_stat_r[i] <= 1'b0;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ==========================================================
    // read data, one cycle after the strobe, zero otherwise
    logic [31:0] rd_nxt;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (reg_addr)
            `OFM_ADDR_KEY:      rd_nxt[7:0] = key_r;
            `OFM_ADDR_ENABLE:   rd_nxt[7:0] = en_r;
            `OFM_ADDR_LOWER:    rd_nxt[8:0] = lower_r;
            `OFM_ADDR_UPPER:    rd_nxt[8:0] = upper_r;
            `OFM_ADDR_RSTGEN:   rd_nxt[0]   = rstgen_r;
            `OFM_ADDR_STATUS:
            begin
                rd_nxt[`OFM_ST_FAULT_BIT] = fault_r; // R2
                rd_nxt[`OFM_ST_STOP_BIT]  = !running; // R1
            end
            `OFM_ADDR_IRQ_STAT: rd_nxt[1:0] = irq_stat_r;
            `OFM_ADDR_IRQ_MASK: rd_nxt[1:0] = irq_mask_r;
            default:            rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rd_nxt;
        else
            reg_rdata <= 32'h0000_0000;
    end

    // ==========================================================
    // checks
    key_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
        wr_at(`OFM_ADDR_KEY) && wkey != `OFM_KEY_OPEN && !soft_init
        |=> key_r == `OFM_KEY_LOCK)
        else $error("bad key value not stored as lock code");

    key_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
        wr_at(`OFM_ADDR_LOWER) && !key_open && !soft_init |=> $stable(lower_r))
        else $error("lower limit written while key closed");

    en_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
        wr_at(`OFM_ADDR_ENABLE) && key_open && wkey == `OFM_EN_ON && !soft_init
        |=> running)
        else $error("enable code did not start detection");

    en_codes_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
        en_r == `OFM_EN_OFF || en_r == `OFM_EN_ON)
        else $error("enable register holds illegal code");

    run_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
        wr_at(`OFM_ADDR_UPPER) && running && !soft_init |=> $stable(upper_r))
        else $error("upper limit changed while running");

    stop_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
        reg_rd && reg_addr == `OFM_ADDR_STATUS |=> reg_rdata[1] == !$past(running))
        else $error("stopped flag read back wrong");

    arm_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
        $rose(state_r == ofm_pkg::OFM_MEAS) |-> $past(arm_cnt_r) == 2'h1 && $past(tgt_e.rise))
        else $error("measurement began before two target edges");

    fault_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
        fault_evt |=> fault_r)
        else $error("fault not flagged");

    rst_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
        fault_evt && rstgen_r |=> warm_rst_req ##1 (en_r == `OFM_EN_OFF && key_r == `OFM_KEY_LOCK))
        else $error("fault did not request and apply warm reset");

    limit_cmp_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
        win_end && (tgt_div4 > {1'b0, upper_r} || tgt_div4 < {1'b0, lower_r})
        |=> fault_r && irq_stat_r[`OFM_IRQ_FAULT_BIT])
        else $error("out-of-limit count not flagged");

    ref_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
        ref_stop |=> stop_cnt_r == 8'h00 && fault_r)
        else $error("reference stop not handled");

endmodule // ofm_freq_monitor

/* bench/ofm_osc_model.sv */
// clock sources and warm-reset observer standing beside the frequency monitor
`timescale 1ns/1ns
module ofm_osc_model
(
    // system
    input  wire logic        clk_sys,
    input  wire logic        warm_rst_req,
    // settings from the bench
    input  wire logic [15:0] tgt_half_ns,
    input  wire logic        ref_run,
    // generated clocks
    output logic             target_clk_in,
    output logic             ref_clk_in,
    // observation
    output int               warm_cnt
);
    // ==========================================================
    // oscillators
    initial target_clk_in = 1'b0;
    initial ref_clk_in = 1'b0;
    initial warm_cnt = 0;

    always #(tgt_half_ns) target_clk_in = ~target_clk_in;

    // a stopped reference holds its last level, as a dead oscillator would
    always #80 if (ref_run) ref_clk_in = ~ref_clk_in;

    // ==========================================================
    // reset generator side: count requests
    always @(posedge clk_sys)
        if (warm_rst_req === 1'b1)
            warm_cnt <= warm_cnt + 1;
endmodule // ofm_osc_model

/* bench/testbench.sv */
// self-checking bench for the frequency monitor with a register model
`timescale 1ns/1ns
`include "ofm_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    // ==========================================================
    // signals
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        target_clk_in;
    logic        ref_clk_in;
    logic        pmode_ok = 1'b1;
    logic        warm_rst_req;
    logic        irq;
    logic [15:0] tgt_half = 16'h0050;
    logic        ref_run = 1'b1;
    int          warm_cnt;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          seed = 32'h1C69915A;
    logic [31:0] m [8];
    logic [31:0] fmask [8] = '{32'hFF, 32'hFF, 32'h1FF, 32'h1FF, 32'h1, 32'h0, 32'h0, 32'h3};
    int          ch [5] = '{80, 80, 160, 80, 120};
    int          cl [5] = '{40, 40, 40, 40, 30};
    int          cu [5] = '{90, 50, 90, 50, 50};
    logic [4:0]  cp = 5'b10111;
    logic [4:0]  cf = 5'b00110;

    always #20 clk_sys = ~clk_sys;

    ofm_freq_monitor ofm_freq_monitor_inst
    (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .target_clk_in (target_clk_in),
        .ref_clk_in    (ref_clk_in),
        .pmode_ok      (pmode_ok),
        .warm_rst_req  (warm_rst_req),
        .irq           (irq)
    );

    ofm_osc_model ofm_osc_model_inst
    (
        .clk_sys       (clk_sys),
        .warm_rst_req  (warm_rst_req),
        .tgt_half_ns   (tgt_half),
        .ref_run       (ref_run),
        .target_clk_in (target_clk_in),
        .ref_clk_in    (ref_clk_in),
        .warm_cnt      (warm_cnt)
    );

    // ==========================================================
    // bus tasks; the model applies the write protection of the device
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d | ($random(seed) & 32'hFFFFFE00);
        reg_wr <= 1'b1;
        if (a == `OFM_ADDR_KEY)
            m[0] = (d[7:0] == `OFM_KEY_OPEN) ? 32'hF9 : 32'h06;
        else if (a == `OFM_ADDR_IRQ_MASK)
            m[7] = d & fmask[7];
        else if (m[0] == 32'hF9 && a == `OFM_ADDR_ENABLE && (d[7:0] == 8'h00 || d[7:0] == 8'hE4))
            m[1] = d & fmask[1];
        else if (m[0] == 32'hF9 && m[1] != 32'hE4 && a >= 8'h08 && a <= 8'h10)
            m[a[4:2]] = d & fmask[a[4:2]];
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        `CHK("reg_rdata", e & k, reg_rdata & k)
    endtask

    task automatic chk_regs();
        foreach (m[i])
            if (i < 5 || i == 7)
                rd(8'(i * 4), m[i], 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
    endtask

    // one measurement with the monitor restarted from stopped
    task automatic run_case(input int h, input int lo, input int up, input logic pm,
                            input logic f);
        wr(`OFM_ADDR_ENABLE, 32'h00);
        tgt_half <= 16'(h);
        pmode_ok <= pm;
        wr(`OFM_ADDR_LOWER, 32'(lo));
        wr(`OFM_ADDR_UPPER, 32'(up));
        wr(`OFM_ADDR_ENABLE, 32'hE4);
        wr(`OFM_ADDR_LOWER, 32'h1FF);
        repeat (2400) @(posedge clk_sys);
        rd(`OFM_ADDR_STATUS, {31'h0, f}, 32'hFFFFFFFF);
        `CHK("irq", f, irq)
        rd(`OFM_ADDR_IRQ_STAT, {31'h0, f}, 32'h1);
        `CHK("irq", 1'b0, irq)
        `CHK("warm_cnt", 0, warm_cnt)
        chk_regs();
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // timeout: about 17000 cycles expected
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        m = '{32'h06, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_regs();
        rd(`OFM_ADDR_STATUS, 32'h2, 32'hFFFFFFFF);
        wr(`OFM_ADDR_LOWER, $random(seed));
        wr(`OFM_ADDR_KEY, 32'hF9);
        wr(`OFM_ADDR_KEY, 32'h33);
        chk_regs();
        wr(`OFM_ADDR_KEY, 32'hF9);
        wr(`OFM_ADDR_ENABLE, 32'h12);
        wr(`OFM_ADDR_LOWER, $random(seed));
        wr(`OFM_ADDR_UPPER, $random(seed));
        wr(`OFM_ADDR_RSTGEN, 32'h0);
        wr(`OFM_ADDR_IRQ_MASK, 32'h3);
        chk_regs();
        for (int i = 0; i < 5; i++)
            run_case(ch[i], cl[i], cu[i], cp[i], cf[i]);
        // in-limit measurement repeated with the reference oscillator still running
        run_case(80, 40, 90, 1'b1, 1'b0);
        // reference-stop bit masked first: the level output must stay low
        wr(`OFM_ADDR_IRQ_MASK, 32'h1);
        ref_run <= 1'b0;
        repeat (150) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        wr(`OFM_ADDR_IRQ_MASK, 32'h3);
        @(negedge clk_sys);
        `CHK("irq", 1'b1, irq)
        rd(`OFM_ADDR_IRQ_STAT, 32'h2, 32'h2);
        `CHK("irq", 1'b0, irq)
        ref_run <= 1'b1;
        // fault with reset generation on: one request, then soft init
        wr(`OFM_ADDR_ENABLE, 32'h00);
        wr(`OFM_ADDR_RSTGEN, 32'h1);
        wr(`OFM_ADDR_UPPER, 32'h32);
        wr(`OFM_ADDR_ENABLE, 32'hE4);
        repeat (2400) @(posedge clk_sys);
        rd(`OFM_ADDR_STATUS, 32'h3, 32'hFFFFFFFF);
        `CHK("warm_cnt", 1, warm_cnt)
        m[0] = 32'h06;
        m[1] = 32'h0;
        m[2] = 32'h0;
        m[3] = 32'h0;
        m[4] = 32'h1;
        chk_regs();
        // relock after setup, then writes bounce
        wr(`OFM_ADDR_KEY, 32'hF9);
        wr(`OFM_ADDR_LOWER, 32'h55);
        wr(`OFM_ADDR_KEY, 32'h06);
        wr(`OFM_ADDR_UPPER, 32'h74);
        chk_regs();
        report_and_stop();
    end
endmodule // testbench
